// >>> common/backlight_pkg.sv
package backlight_pkg;

  // ==========================================================
  // clock and time base
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned MS_PER_SEC    = 1000;
  localparam int unsigned CYCLES_PER_MS = CLK_HZ / MS_PER_SEC;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [5:0] IDX_CTRL    = 6'h00;
  localparam logic [5:0] IDX_MAX_CUR = 6'h01;
  localparam logic [5:0] IDX_DIM_CUR = 6'h02;
  localparam logic [5:0] IDX_STATUS  = 6'h03;
  localparam logic [5:0] IDX_SINK    = 6'h05;
  localparam logic [5:0] IDX_OFF     = 6'h06;
  localparam logic [5:0] IDX_DIM     = 6'h07;
  localparam logic [5:0] IDX_FADE    = 6'h08;

  // ==========================================================
  // field positions
  localparam int CTRL_ON_BIT  = 0;
  localparam int CODE_MSB     = 6;
  localparam int FADE_OUT_MSB = 7;
  localparam int FADE_OUT_LSB = 4;
  localparam int FADE_IN_MSB  = 3;
  localparam int FADE_IN_LSB  = 0;
  localparam int STAT_PH_LSB  = 8;
  localparam int STAT_SEC_LSB = 16;

  // ==========================================================
  // values after reset
  localparam logic [6:0] SINK_RST    = 7'h00;
  localparam logic [6:0] OFF_RST     = 7'h00;
  localparam logic [6:0] DIM_RST     = 7'h00;
  localparam logic [7:0] FADE_RST    = 8'h00;
  localparam logic [6:0] MAX_CUR_RST = 7'h7F;
  localparam logic [6:0] DIM_CUR_RST = 7'h20;

  // ==========================================================
  // fade timing, all for a full-scale swing of 127 codes
  localparam logic [6:0]  FULL_SCALE_CODE = 7'h7F;
  localparam logic [12:0] RAPID_FADE_MS   = 13'h0064;
  localparam logic [12:0] FADE_STEP_MS    = 13'h012C;
  localparam logic [12:0] FADE_LONG_MS    = 13'h0DAC;
  localparam logic [12:0] FADE_LONG_INC   = 13'h01F4;
  localparam logic [3:0]  FADE_LONG_FIRST = 4'hB;

  // ==========================================================
  // light phases
  typedef enum logic [1:0] {PH_OFF, PH_FULL, PH_DIM} phase_e;

endpackage

// >>> hdl/step_timer.sv
`timescale 1ns/1ps
// ==========================================================
// period divider: one-cycle tick every PERIOD cycles
module step_timer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // control
  input  wire logic        restart,
  input  wire logic [31:0] period,
  // event
  output logic             tick
);

  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;

  // count up, wrap at period; restart holds the phase at zero
  always_comb begin
    tick    = 1'b0;
    cnt_nxt = cnt_r + 32'h0000_0001;
    if (restart) begin
      cnt_nxt = 32'h0000_0000;
    end else if (cnt_r + 32'h0000_0001 >= period) begin
      tick    = 1'b1;
      cnt_nxt = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 32'h0000_0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule

// >>> hdl/backlight_ctrl.sv
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
// Function
// - Sink select bits 6..0 (sink seven down to sink one) set to one make that sink independent.
// - A sink select bit at zero makes that sink follow the group enable and group current.
// - Off delay bits 6..0 give N seconds of delay, up to 127 seconds.
// - An off delay of zero disables the automatic turn-off.
// - Off expiry turns the light off; with dimming on, off counting starts after the dim expiry.
// - Dim delay bits 6..0 give N seconds, zero disables, expiry drops to the dim current.
// - Dim counting starts only once the current has reached the maximum.
// - Fade-out rate sits in bits 7..4; zero means a rapid change within about 100 ms.
// - A nonzero fade-out rate ramps down gradually to the dim or off level.
// - Codes 1..10 give 0.3 s per code; codes 11..15 give 3.5 s to 5.5 s in 0.5 s steps.
// - Times are for a full-scale swing; shorter swings keep the same rate.
// - Fade-in rate sits in bits 3..0; zero means a rapid rise within about 100 ms.
// - A nonzero fade-in rate ramps up to the maximum whenever the light is turned on.
// - Fade-in uses the same time encoding, referenced to a full-scale rise.
module backlight_ctrl #(
  parameter int unsigned MS_CYCLES  = backlight_pkg::CYCLES_PER_MS,
  parameter int unsigned SEC_CYCLES = backlight_pkg::CLK_HZ
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // sink drive
  output logic      [6:0]  SINK_INDEPENDENT,
  output logic      [6:0]  SINK_GROUP_ON,
  output logic      [6:0]  GROUP_LEVEL
);

  // ==========================================================
  // declarations
  logic       wr_pend_r, wr_pend_nxt;
  logic [5:0] addr_r, addr_nxt;
  logic       addr_ok_r, addr_ok_nxt;
  logic [6:0] sink_sel_r, sink_sel_nxt;
  logic [6:0] off_secs_r, off_secs_nxt;
  logic [6:0] dim_secs_r, dim_secs_nxt;
  logic [7:0] fade_r, fade_nxt;
  logic       light_on_r, light_on_nxt;
  logic [6:0] max_code_r, max_code_nxt;
  logic [6:0] dim_code_r, dim_code_nxt;
  logic       on_write, off_write;

  backlight_pkg::phase_e phase_r, phase_nxt;
  logic [6:0]  level_r, level_nxt;
  logic [6:0]  secs_r, secs_nxt;
  logic [6:0]  target;
  logic [6:0]  sink_ind_r, sink_ind_nxt;
  logic [6:0]  sink_grp_r, sink_grp_nxt;
  logic        counting;
  logic [6:0]  limit;
  logic        sec_tick;
  logic        step_tick;
  logic        going_up;
  logic [3:0]  rate_code;
  logic [31:0] step_period;

  // ==========================================================
  // fade code to full-scale time in ms
  function automatic logic [12:0] fade_ms(input logic [3:0] code);
    logic [12:0] ms;
    ms = backlight_pkg::RAPID_FADE_MS;
    if (code == 4'h0) begin
      ms = backlight_pkg::RAPID_FADE_MS;
    end else if (code < backlight_pkg::FADE_LONG_FIRST) begin
      ms = 13'(backlight_pkg::FADE_STEP_MS * {9'h000, code});
    end else begin
      ms = 13'(backlight_pkg::FADE_LONG_MS + backlight_pkg::FADE_LONG_INC
            * {9'h000, 4'(code - backlight_pkg::FADE_LONG_FIRST)});
    end
    return ms;
  endfunction

  // ==========================================================
  // ahb-lite slave: zero wait states, always okay
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  // decode of an accepted address phase; unmapped writes are dropped
  always_comb begin
    wr_pend_nxt = 1'b0;
    addr_nxt    = addr_r;
    addr_ok_nxt = addr_ok_r;
    if (HSEL && HREADY && HTRANS[1]) begin
      wr_pend_nxt = HWRITE;
      addr_nxt    = HADDR[7:2];
      addr_ok_nxt = (HADDR[31:8] == 24'h00_0000);
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_pend_r <= 1'b0;
      addr_r    <= 6'h00;
      addr_ok_r <= 1'b0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      addr_r    <= addr_nxt;
      addr_ok_r <= addr_ok_nxt;
    end
  end

  // read mux from registered state; unmapped reads give zero
  always_comb begin
    HRDATA = 32'h0000_0000;
    if (addr_ok_r) begin
      case (addr_r)
        backlight_pkg::IDX_CTRL:    HRDATA = {31'h0000_0000, light_on_r};
        backlight_pkg::IDX_MAX_CUR: HRDATA = {25'h000_0000, max_code_r};
        backlight_pkg::IDX_DIM_CUR: HRDATA = {25'h000_0000, dim_code_r};
        backlight_pkg::IDX_STATUS: begin
          HRDATA[6:0] = level_r;
          HRDATA[backlight_pkg::STAT_PH_LSB +: 2]  = phase_r;
          HRDATA[backlight_pkg::STAT_SEC_LSB +: 7] = secs_r;
        end
        backlight_pkg::IDX_SINK: HRDATA = {25'h000_0000, sink_sel_r};
        backlight_pkg::IDX_OFF:  HRDATA = {25'h000_0000, off_secs_r};
        backlight_pkg::IDX_DIM:  HRDATA = {25'h000_0000, dim_secs_r};
        backlight_pkg::IDX_FADE: HRDATA = {24'h00_0000, fade_r};
        default:                 HRDATA = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // configuration registers, written in the data phase
  always_comb begin
    sink_sel_nxt = sink_sel_r;
    off_secs_nxt = off_secs_r;
    dim_secs_nxt = dim_secs_r;
    fade_nxt     = fade_r;
    light_on_nxt = light_on_r;
    max_code_nxt = max_code_r;
    dim_code_nxt = dim_code_r;
    on_write     = 1'b0;
    off_write    = 1'b0;
    if (wr_pend_r && addr_ok_r) begin
      case (addr_r)
        backlight_pkg::IDX_CTRL: begin
          light_on_nxt = HWDATA[backlight_pkg::CTRL_ON_BIT];
          on_write     = HWDATA[backlight_pkg::CTRL_ON_BIT];
          off_write    = !HWDATA[backlight_pkg::CTRL_ON_BIT];
        end
        backlight_pkg::IDX_MAX_CUR: max_code_nxt = HWDATA[backlight_pkg::CODE_MSB:0];
        backlight_pkg::IDX_DIM_CUR: dim_code_nxt = HWDATA[backlight_pkg::CODE_MSB:0];
        // bit 7 of sink, off and dim is not stored, so it reads back as zero
        backlight_pkg::IDX_SINK: sink_sel_nxt = HWDATA[6:0];
        backlight_pkg::IDX_OFF:  off_secs_nxt = HWDATA[6:0];
        backlight_pkg::IDX_DIM:  dim_secs_nxt = HWDATA[6:0];
        backlight_pkg::IDX_FADE: fade_nxt     = HWDATA[7:0];
        default: begin
          sink_sel_nxt = sink_sel_r;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sink_sel_r <= backlight_pkg::SINK_RST;
      off_secs_r <= backlight_pkg::OFF_RST;
      dim_secs_r <= backlight_pkg::DIM_RST;
      fade_r     <= backlight_pkg::FADE_RST;
      light_on_r <= 1'b0;
      max_code_r <= backlight_pkg::MAX_CUR_RST;
      dim_code_r <= backlight_pkg::DIM_CUR_RST;
    end else begin
      sink_sel_r <= sink_sel_nxt;
      off_secs_r <= off_secs_nxt;
      dim_secs_r <= dim_secs_nxt;
      fade_r     <= fade_nxt;
      light_on_r <= light_on_nxt;
      max_code_r <= max_code_nxt;
      dim_code_r <= dim_code_nxt;
    end
  end

  // ==========================================================
  // time bases
  // ramp rate is picked by direction; a step is 1/127 of the full-scale time,
  // so a short swing takes proportionally less time at the same rate
  assign going_up  = (target > level_r);
  assign rate_code = going_up ? fade_r[backlight_pkg::FADE_IN_MSB:backlight_pkg::FADE_IN_LSB]
                              : fade_r[backlight_pkg::FADE_OUT_MSB:backlight_pkg::FADE_OUT_LSB];
  // the divide is by a constant, so it folds to a multiply network
  assign step_period = ({19'h0_0000, fade_ms(rate_code)} * MS_CYCLES)
                       / {25'h000_0000, backlight_pkg::FULL_SCALE_CODE};

  // seconds tick only runs while a delay is counting; an on write at full current clears the count but not the tick phase
  step_timer u_sec_timer (
    .clk     (CLK),
    .rstn    (RSTN),
    .restart (!counting),
    .period  (SEC_CYCLES),
    .tick    (sec_tick)
  );

  // ramp step timer idles at the target level
  step_timer u_step_timer (
    .clk     (CLK),
    .rstn    (RSTN),
    .restart (level_r == target),
    .period  (step_period),
    .tick    (step_tick)
  );

  // ==========================================================
  // light engine: phase, level ramp and delay counters
  always_comb begin
    case (phase_r)
      backlight_pkg::PH_FULL: target = max_code_r;
      backlight_pkg::PH_DIM:  target = dim_code_r;
      default:                target = 7'h00;
    endcase
  end

  // which delay is running: dim first, then off; dim waits for full current
  always_comb begin
    counting = 1'b0;
    limit    = off_secs_r;
    case (phase_r)
      backlight_pkg::PH_FULL: begin
        if (level_r == max_code_r) begin
          if (dim_secs_r != 7'h00) begin
            counting = 1'b1;
            limit    = dim_secs_r;
          end else begin
            counting = (off_secs_r != 7'h00);
            limit    = off_secs_r;
          end
        end
      end
      backlight_pkg::PH_DIM: begin
        counting = (off_secs_r != 7'h00);
        limit    = off_secs_r;
      end
      default: begin
        counting = 1'b0;
      end
    endcase
  end

  always_comb begin
    phase_nxt = phase_r;
    level_nxt = level_r;
    secs_nxt  = counting ? secs_r : 7'h00;
    // one level step per tick toward the target
    if (step_tick && level_r != target) begin
      level_nxt = going_up ? 7'(level_r + 7'h01) : 7'(level_r - 7'h01);
    end
    // delay expiry
    if (counting && sec_tick) begin
      if (7'(secs_r + 7'h01) == limit) begin
        secs_nxt = 7'h00;
        if (phase_r == backlight_pkg::PH_FULL && dim_secs_r != 7'h00) begin
          phase_nxt = backlight_pkg::PH_DIM;
        end else begin
          phase_nxt = backlight_pkg::PH_OFF;
        end
      end else begin
        secs_nxt = 7'(secs_r + 7'h01);
      end
    end
    // software writes override the timers
    if (on_write) begin
      phase_nxt = backlight_pkg::PH_FULL;
      secs_nxt  = 7'h00;
    end else if (off_write) begin
      phase_nxt = backlight_pkg::PH_OFF;
      secs_nxt  = 7'h00;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      phase_r <= backlight_pkg::PH_OFF;
      level_r <= 7'h00;
      secs_r  <= 7'h00;
    end else begin
      phase_r <= phase_nxt;
      level_r <= level_nxt;
      secs_r  <= secs_nxt;
    end
  end

  // ==========================================================
  // sink routing, registered so outputs come from flops
  always_comb begin
    sink_ind_nxt = sink_sel_r;
    sink_grp_nxt = ~sink_sel_r & {7{level_nxt != 7'h00}};
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sink_ind_r <= 7'h00;
      sink_grp_r <= 7'h00;
    end else begin
      sink_ind_r <= sink_ind_nxt;
      sink_grp_r <= sink_grp_nxt;
    end
  end

  assign SINK_INDEPENDENT = sink_ind_r;
  assign SINK_GROUP_ON    = sink_grp_r;
  assign GROUP_LEVEL      = level_r;

endmodule

// >>> bench/backlight_sva.sv
`timescale 1ns/1ps
// ==========================================================
// bus and light output checks
module backlight_sva #(
  parameter int unsigned MS_CYCLES  = 127,
  parameter int unsigned SEC_CYCLES = 2000
) (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RSTN,
  // ahb-lite
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [2:0]  HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  // sink drive
  input wire logic [6:0]  SINK_INDEPENDENT,
  input wire logic [6:0]  SINK_GROUP_ON,
  input wire logic [6:0]  GROUP_LEVEL
);
  // fastest step is 100 ms over 127 codes, less some slack
  localparam int unsigned GAP_MIN = MS_CYCLES * 100 / 127 - 5;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic        ap_v_r;
  logic        ap_w_r;
  logic [31:0] ap_a_r;
  logic [6:0]  lv_r;
  logic [15:0] gap_r;
  logic        rd_dp;
  // address phase kept for its data phase
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ap_v_r <= 1'b0;
      ap_w_r <= 1'b0;
      ap_a_r <= 32'h00000000;
    end else if (HREADY) begin
      ap_v_r <= HSEL && HTRANS[1];
      ap_w_r <= HWRITE;
      ap_a_r <= HADDR;
    end
  end
  // cycles since the level last moved, saturating
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      lv_r  <= 7'h00;
      gap_r <= 16'h0000;
    end else begin
      lv_r  <= GROUP_LEVEL;
      gap_r <= (GROUP_LEVEL != lv_r) ? 16'h0000 : gap_r + {15'h0000, gap_r != 16'hFFFF};
    end
  end
  assign rd_dp = ap_v_r && !ap_w_r;
  // ==========================================================
  // assertions
  AST_OKAY: assert property (HREADYOUT && !HRESP)
    else $error("bus not ready or not okay");
  AST_GROUP_ON: assert property (
    SINK_GROUP_ON == ((GROUP_LEVEL != 7'h00) ? ~SINK_INDEPENDENT : 7'h00))
    else $error("group sink enables wrong");
  AST_NO_OVERLAP: assert property ((SINK_INDEPENDENT & SINK_GROUP_ON) == 7'h00)
    else $error("independent sink also on group");
  AST_SINK_WR: assert property (
    ap_v_r && ap_w_r && ap_a_r == 32'h00000014 && HREADY
    |-> ##2 SINK_INDEPENDENT == $past(HWDATA[6:0], 2))
    else $error("sink select write not applied");
  AST_RSVD_RD: assert property (
    rd_dp && (ap_a_r == 32'h00000014 || ap_a_r == 32'h00000018 || ap_a_r == 32'h0000001C)
    |-> HRDATA[31:7] == 25'h0000000)
    else $error("reserved bits read nonzero");
  AST_UNMAPPED: assert property (
    rd_dp && (ap_a_r[31:8] != 24'h000000 || ap_a_r[7:2] > 6'h08 || ap_a_r[7:2] == 6'h04)
    |-> HRDATA == 32'h00000000)
    else $error("unmapped read nonzero");
  AST_STEP_ONE: assert property (
    GROUP_LEVEL != lv_r |-> GROUP_LEVEL == lv_r + 7'h01 || GROUP_LEVEL == lv_r - 7'h01)
    else $error("level jumped by more than one");
  AST_STEP_GAP: assert property (GROUP_LEVEL != lv_r |-> gap_r >= GAP_MIN)
    else $error("level steps too close");
endmodule
bind backlight_ctrl backlight_sva #(.MS_CYCLES(MS_CYCLES), .SEC_CYCLES(SEC_CYCLES)) u_sva (
  .CLK(CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .SINK_INDEPENDENT(SINK_INDEPENDENT), .SINK_GROUP_ON(SINK_GROUP_ON),
  .GROUP_LEVEL(GROUP_LEVEL)
);

// >>> bench/ahb_host.sv
`timescale 1ns/1ps
// ==========================================================
// host side: single-word ahb-lite transfers
module ahb_host (
  // clock
  input  wire logic        clk,
  // response
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // request
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  bit hang;
  // idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    hang = 1'b0;
  end
  // bounded wait for hready at a rising edge
  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (hready !== 1'b1 && i < 64);
    if (hready !== 1'b1) hang = 1'b1;
  endtask
  // one transfer; read data taken at the closing edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    hwdata <= ~d; // released data must not look valid
  endtask
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// register and light sequencing tests
module tb_top;
  localparam int unsigned MSC = 127;
  localparam int unsigned SECC = 2000;
  logic        clk;
  logic        rstn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [6:0]  sink_ind;
  logic [6:0]  sink_on;
  logic [6:0]  level;
  logic [31:0] q;
  int          n_fail;
  int          check_count;
  int          n;
  int          t;
  logic [3:0]  codes [4] = '{4'h0, 4'h1, 4'hB, 4'hF};
  logic [5:0]  ids [5] = '{backlight_pkg::IDX_SINK, backlight_pkg::IDX_OFF,
                           backlight_pkg::IDX_DIM, backlight_pkg::IDX_FADE, 6'h3F};
  ahb_host u_host (.clk(clk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  backlight_ctrl #(.MS_CYCLES(MSC), .SEC_CYCLES(SECC)) u_backlight_ctrl (
    .CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .SINK_INDEPENDENT(sink_ind), .SINK_GROUP_ON(sink_on), .GROUP_LEVEL(level));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // full-scale ramp time in ms, worked out here on its own
  function automatic int fms(input logic [3:0] c);
    fms = (c == 4'h0) ? 100 : (c <= 4'hA) ? 300 * c : 3500 + 500 * (c - 11);
  endfunction
  task automatic report_and_stop();
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // register access by word index
  task automatic acc(input logic w, input logic [5:0] i, input logic [31:0] d);
    u_host.xfer(w, {24'h000000, i, 2'h0}, d, q);
    if (u_host.hang) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  // cycles until the level moves; a stuck level ends the run
  task automatic wait_chg();
    logic [6:0] lv;
    lv = level;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (level === lv && n < 12000);
    if (level === lv) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    rstn = 1'b0;
    n_fail = 0;
    check_count = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      acc(1'b0, ids[k], 32'h0);
      chk("reset", q, 32'h0);
    end
    // reserved bit 7 and unmapped space ignore writes
    for (int k = 0; k < 5; k++) begin
      acc(1'b1, ids[k], 32'hFFFFFFFF);
      acc(1'b0, ids[k], 32'h0);
      chk("rsvd", q, (k == 3) ? 32'hFF : (k == 4) ? 32'h0 : 32'h7F);
    end
    chk("ind", 32'(sink_ind), 32'h7F);
    acc(1'b1, backlight_pkg::IDX_OFF, 32'h0);
    acc(1'b1, backlight_pkg::IDX_DIM, 32'h0);
    acc(1'b1, backlight_pkg::IDX_SINK, 32'h2A);
    acc(1'b1, backlight_pkg::IDX_MAX_CUR, 32'h3);
    acc(1'b1, backlight_pkg::IDX_DIM_CUR, 32'h1);
    // ramp step spacing for fade codes 0, 1, 11 and 15, up then down
    for (int k = 0; k < 4; k++) begin
      acc(1'b1, backlight_pkg::IDX_FADE, {24'h000000, codes[k], codes[k]});
      acc(1'b1, backlight_pkg::IDX_CTRL, 32'h1);
      wait_chg();
      wait_chg();
      chk("up", 32'(n), 32'(fms(codes[k]) * MSC / 127));
      wait_chg();
      chk("max", 32'(level), 32'h3);
      chk("grp", 32'(sink_on), 32'h55);
      chk("ind2", 32'(sink_ind), 32'h2A);
      acc(1'b1, backlight_pkg::IDX_CTRL, 32'h0);
      wait_chg();
      wait_chg();
      chk("down", 32'(n), 32'(fms(codes[k]) * MSC / 127));
      wait_chg();
    end
    // zero delays keep the light at max
    acc(1'b1, backlight_pkg::IDX_FADE, 32'h0);
    acc(1'b1, backlight_pkg::IDX_CTRL, 32'h1);
    repeat (3) wait_chg();
    repeat (5000) @(posedge clk);
    chk("hold", 32'(level), 32'h3);
    // dim after 2 s, off 3 s after that; tick phase may be free running
    acc(1'b1, backlight_pkg::IDX_DIM, 32'h2);
    acc(1'b1, backlight_pkg::IDX_OFF, 32'h3);
    acc(1'b1, backlight_pkg::IDX_CTRL, 32'h1);
    wait_chg();
    chk("dim_t", 32'(n >= SECC && n <= 2 * SECC + 150), 32'h1);
    wait_chg();
    t = n;
    chk("dim_lv", 32'(level), 32'h1);
    wait_chg();
    t = t + n;
    chk("off_t", 32'(t >= 2 * SECC && t <= 3 * SECC + 250), 32'h1);
    chk("off_lv", 32'(level), 32'h0);
    chk("off_grp", 32'(sink_on), 32'h0);
    // slow fade-in outlasts the dim delay: dim must wait for full current
    acc(1'b1, backlight_pkg::IDX_FADE, 32'h0F);
    acc(1'b1, backlight_pkg::IDX_CTRL, 32'h1);
    repeat (3) wait_chg();
    chk("dim_wait", 32'(level), 32'h3);
    report_and_stop();
  end
endmodule
